// >>> mmd_decode.sv
// What this block does
// - Addresses 0x0000 to 0x004F select the direct-page peripheral registers.
// - Addresses 0x0050 to 0x008F select the 64-byte parameter registers.
// - Addresses 0x0090 to 0x028F select on-chip RAM.
// - Addresses 0x1800 to 0x182B select the high-page registers.
// - Flash is 16K; upper 8K belongs to firmware, not user code.
// - All vectors are redirected to the user area 0xDFE0 to 0xDFFF.
// - Every reset source fetches its vector from 0xDFFE:0xDFFF.
// - Two-byte user vectors in fixed order; DFE2, DFE4, DFFA reserved.
// - Sixteen nonvolatile flash bytes at 0xFFB0; three load working registers at reset.
// - Eight-byte comparison key in that area may unlock secured memory.
// - First 256 addresses reachable by low byte; direct-page writes are full bytes, flag bits not writable.
// - Zero-marked unused bits read 0; other reserved bits read 0 here.
`timescale 1ns/10ps
module mmd_decode import mmd_pkg::*; #(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 8
) (
   input  wire logic              sys_clk_in,
   input  wire logic              rst_n_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic              direct_mode_in,
   input  wire logic              rd_in,
   input  wire logic              wr_in,
   input  wire logic [DATA_W-1:0] wdata_in,
   input  wire logic [DATA_W-1:0] ext_rdata_in,
   input  wire logic              keypad_event_in,
   input  wire logic              tmr_ovf_in,
   input  wire logic              tmr_ch0_in,
   input  wire logic              tmr_ch1_in,
   input  wire logic              wake_event_in,
   input  wire logic              prst_event_in,
   input  wire logic [15:0]       tmr_count_in,
   input  wire logic [5:0]        wake_count_in,
   input  wire logic              reset_source_in,
   input  wire logic [3:0]        irq_source_in,
   input  wire logic              key_match_in,
   output logic [DATA_W-1:0]      rdata_out,
   output logic [15:0]            full_addr_out,
   output logic                   sel_param_out,
   output logic                   sel_ram_out,
   output logic                   sel_high_out,
   output logic                   sel_flash_out,
   output logic                   sel_firmware_out,
   output logic                   sel_nvreg_out,
   output logic                   flash_write_block_out,
   output logic                   fetch_nvload_out,
   output logic [15:0]            nvload_addr_out,
   output logic [15:0]            vector_addr_out,
   output logic                   vector_valid_out,
   output logic [DATA_W-1:0]      nv_work_out [3],
   output logic                   secure_unlock_out,
   output logic [4:0]             port_a_data_out,
   output logic [3:0]             port_a_pull_out,
   output logic [3:0]             port_a_dir_out,
   output logic [1:0]             port_b_data_out,
   output logic [1:0]             port_b_pull_out,
   output logic [1:0]             port_b_dir_out,
   output logic [7:0]             keypad_ctrl_out,
   output logic [7:0]             tmr_ctrl_out,
   output logic [15:0]            tmr_modulo_out,
   output logic                   tmr_count_clear_out,
   output logic [7:0]             tmr_ch0_ctrl_out,
   output logic [15:0]            tmr_ch0_value_out,
   output logic [7:0]             tmr_ch1_ctrl_out,
   output logic [15:0]            tmr_ch1_value_out,
   output logic [5:0]             wake_div_out,
   output logic [5:0]             wake_time_out,
   output logic [5:0]             prst_time_out,
   output logic                   wake_sel_out
);

   typedef struct packed {
      mmd_state_type st;
      logic [1:0]    load_idx;
      logic [7:0]    nv0;
      logic [7:0]    nv1;
      logic [7:0]    nv2;
      logic [7:0]    pa_data;
      logic [7:0]    pa_pull;
      logic [7:0]    pa_dir;
      logic [7:0]    pb_data;
      logic [7:0]    pb_pull;
      logic [7:0]    pb_dir;
      logic [7:0]    key_sc;
      logic [7:0]    key_pe;
      logic [7:0]    key_es;
      logic [7:0]    tmr_sc;
      logic [15:0]   tmr_mod;
      logic [7:0]    c0_sc;
      logic [15:0]   c0_val;
      logic [7:0]    c1_sc;
      logic [15:0]   c1_val;
      logic [7:0]    wdiv;
      logic [7:0]    wcs;
      logic [7:0]    pcs;
      logic [7:0]    wss;
      logic [7:0]    cnt_latch;
      logic          cnt_clr;
      logic [7:0]    rdata;
   } mmd_regs_type;

   mmd_regs_type  r_q;
   mmd_regs_type  r_d;
   logic [15:0]   eff_addr;
   mmd_region_type region;
   logic          dp_wr;

   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // Sticky flag: hardware set wins over a software acknowledge
   function automatic logic flag_next(input logic cur, input logic set, input logic clr);
      flag_next = set | (cur & ~clr);
   endfunction

   // Direct addressing supplies only the low byte; high byte is zero
   assign eff_addr = direct_mode_in ? {8'h00, addr_in[7:0]} : addr_in[15:0];
   assign dp_wr = wr_in && region == MMD_REG_DIRECT;

   always_comb begin
      region = MMD_REG_NONE;
      if (in_range(eff_addr, MMD_DIRECT_LO, MMD_DIRECT_HI)) begin
         region = MMD_REG_DIRECT;
      end else if (in_range(eff_addr, MMD_PARAM_LO, MMD_PARAM_HI)) begin
         region = MMD_REG_PARAM;
      end else if (in_range(eff_addr, MMD_RAM_LO, MMD_RAM_HI)) begin
         region = MMD_REG_RAM;
      end else if (in_range(eff_addr, MMD_HIGH_LO, MMD_HIGH_HI)) begin
         region = MMD_REG_HIGH;
      end else if (in_range(eff_addr, MMD_NVREG_LO, MMD_NVREG_HI)) begin
         region = MMD_REG_NVREG;
      end else if (in_range(eff_addr, MMD_FLASH_LO, MMD_USER_TOP)) begin
         region = MMD_REG_FLASH;
      end else if (eff_addr >= MMD_FW_LO) begin
         region = MMD_REG_FW;
      end
   end

   always_comb begin
      r_d = r_q;
      r_d.cnt_clr = 1'b0;
      r_d.rdata = MMD_ZERO8;
      case (r_q.st)
         // Three nonvolatile bytes are fetched over the flash port before the core runs
         MMD_ST_LOAD0: begin
            r_d.st = MMD_ST_LOAD1;
         end
         MMD_ST_LOAD1: begin
            case (r_q.load_idx)
               2'd0: r_d.nv0 = ext_rdata_in;
               2'd1: r_d.nv1 = ext_rdata_in;
               default: r_d.nv2 = ext_rdata_in;
            endcase
            if (r_q.load_idx == 2'd2) begin
               r_d.st = MMD_ST_RUN;
            end else begin
               r_d.load_idx = r_q.load_idx + 2'd1;
               r_d.st = MMD_ST_LOAD0;
            end
         end
         MMD_ST_RUN: begin
            if (rd_in) begin
               if (region == MMD_REG_DIRECT) begin
                  case (eff_addr[7:0])
                     MMD_PORT_A_DATA: r_d.rdata = r_q.pa_data;
                     MMD_PORT_A_PULL: r_d.rdata = r_q.pa_pull;
                     MMD_PORT_A_DIR:  r_d.rdata = r_q.pa_dir;
                     MMD_PORT_B_DATA: r_d.rdata = r_q.pb_data;
                     MMD_PORT_B_PULL: r_d.rdata = r_q.pb_pull;
                     MMD_PORT_B_DIR:  r_d.rdata = r_q.pb_dir;
                     MMD_KEY_SC:      r_d.rdata = r_q.key_sc & MMD_MASK_KEY_SC;
                     MMD_KEY_PE:      r_d.rdata = r_q.key_pe;
                     MMD_KEY_ES:      r_d.rdata = r_q.key_es;
                     MMD_TMR_SC:      r_d.rdata = r_q.tmr_sc;
                     MMD_TMR_CNTH: begin
                        // High read freezes the low byte for a coherent 16-bit read
                        r_d.rdata = tmr_count_in[15:8];
                        r_d.cnt_latch = tmr_count_in[7:0];
                     end
                     MMD_TMR_CNTL:    r_d.rdata = r_q.cnt_latch;
                     MMD_TMR_MODH:    r_d.rdata = r_q.tmr_mod[15:8];
                     MMD_TMR_MODL:    r_d.rdata = r_q.tmr_mod[7:0];
                     MMD_TMR_C0SC:    r_d.rdata = r_q.c0_sc & MMD_MASK_CH_SC;
                     MMD_TMR_C0VH:    r_d.rdata = r_q.c0_val[15:8];
                     MMD_TMR_C0VL:    r_d.rdata = r_q.c0_val[7:0];
                     MMD_TMR_C1SC:    r_d.rdata = r_q.c1_sc & MMD_MASK_CH_SC;
                     MMD_TMR_C1VH:    r_d.rdata = r_q.c1_val[15:8];
                     MMD_TMR_C1VL:    r_d.rdata = r_q.c1_val[7:0];
                     MMD_WAKE_DIV:    r_d.rdata = r_q.wdiv;
                     MMD_WAKE_CS:     r_d.rdata = {r_q.wcs[MMD_WFLAG_BIT], 1'b0, r_q.wcs[5:0]};
                     MMD_PRST_CS:     r_d.rdata = {r_q.pcs[MMD_WFLAG_BIT], 1'b0, r_q.pcs[5:0]};
                     MMD_WAKE_SS:     r_d.rdata = {r_q.wss[7], 1'b0, wake_count_in};
                     default:         r_d.rdata = MMD_ZERO8;
                  endcase
               end else begin
                  r_d.rdata = ext_rdata_in;
               end
            end
            // Full-byte writes; the core's bit instructions arrive as read-modify-write
            if (dp_wr) begin
               case (eff_addr[7:0])
                  MMD_PORT_A_DATA: r_d.pa_data = wdata_in & MMD_MASK_PA_DATA;
                  MMD_PORT_A_PULL: r_d.pa_pull = wdata_in & MMD_MASK_NIBBLE;
                  MMD_PORT_A_DIR:  r_d.pa_dir = wdata_in & MMD_MASK_NIBBLE;
                  MMD_PORT_B_DATA: r_d.pb_data = wdata_in & MMD_MASK_PAIR;
                  MMD_PORT_B_PULL: r_d.pb_pull = wdata_in & MMD_MASK_PAIR;
                  MMD_PORT_B_DIR:  r_d.pb_dir = wdata_in & MMD_MASK_PAIR;
                  MMD_KEY_SC:      r_d.key_sc = {r_q.key_sc[7:4], r_q.key_sc[MMD_KEY_FLAG_BIT], 1'b0, wdata_in[1:0]};
                  MMD_KEY_PE:      r_d.key_pe = wdata_in & MMD_MASK_NIBBLE;
                  MMD_KEY_ES:      r_d.key_es = wdata_in & MMD_MASK_NIBBLE;
                  MMD_TMR_SC:      r_d.tmr_sc = {r_q.tmr_sc[MMD_TOF_BIT], wdata_in[6:0]};
                  MMD_TMR_CNTH:    r_d.cnt_clr = 1'b1;
                  MMD_TMR_CNTL:    r_d.cnt_clr = 1'b1;
                  MMD_TMR_MODH:    r_d.tmr_mod[15:8] = wdata_in;
                  MMD_TMR_MODL:    r_d.tmr_mod[7:0] = wdata_in;
                  MMD_TMR_C0SC:    r_d.c0_sc = {r_q.c0_sc[MMD_CH_FLAG_BIT], wdata_in[6:2], 2'b00};
                  MMD_TMR_C0VH:    r_d.c0_val[15:8] = wdata_in;
                  MMD_TMR_C0VL:    r_d.c0_val[7:0] = wdata_in;
                  MMD_TMR_C1SC:    r_d.c1_sc = {r_q.c1_sc[MMD_CH_FLAG_BIT], wdata_in[6:2], 2'b00};
                  MMD_TMR_C1VH:    r_d.c1_val[15:8] = wdata_in;
                  MMD_TMR_C1VL:    r_d.c1_val[7:0] = wdata_in;
                  MMD_WAKE_DIV:    r_d.wdiv = wdata_in & MMD_MASK_SIX;
                  MMD_WAKE_CS:     r_d.wcs = {r_q.wcs[MMD_WFLAG_BIT], 1'b0, wdata_in[5:0]};
                  MMD_PRST_CS:     r_d.pcs = {r_q.pcs[MMD_WFLAG_BIT], 1'b0, wdata_in[5:0]};
                  MMD_WAKE_SS:     r_d.wss = {wdata_in[7], 7'h00};
                  default:         ;
               endcase
            end
            // Timer flags clear on a 0 written to the flag bit
            r_d.key_sc[MMD_KEY_FLAG_BIT] = flag_next(r_q.key_sc[MMD_KEY_FLAG_BIT], keypad_event_in,
               dp_wr && eff_addr[7:0] == MMD_KEY_SC && wdata_in[MMD_KEY_ACK_BIT]);
            r_d.tmr_sc[MMD_TOF_BIT] = flag_next(r_q.tmr_sc[MMD_TOF_BIT], tmr_ovf_in,
               dp_wr && eff_addr[7:0] == MMD_TMR_SC && !wdata_in[MMD_TOF_BIT]);
            r_d.c0_sc[MMD_CH_FLAG_BIT] = flag_next(r_q.c0_sc[MMD_CH_FLAG_BIT], tmr_ch0_in,
               dp_wr && eff_addr[7:0] == MMD_TMR_C0SC && !wdata_in[MMD_CH_FLAG_BIT]);
            r_d.c1_sc[MMD_CH_FLAG_BIT] = flag_next(r_q.c1_sc[MMD_CH_FLAG_BIT], tmr_ch1_in,
               dp_wr && eff_addr[7:0] == MMD_TMR_C1SC && !wdata_in[MMD_CH_FLAG_BIT]);
            r_d.wcs[MMD_WFLAG_BIT] = flag_next(r_q.wcs[MMD_WFLAG_BIT], wake_event_in,
               dp_wr && eff_addr[7:0] == MMD_WAKE_CS && wdata_in[MMD_WACK_BIT]);
            r_d.pcs[MMD_WFLAG_BIT] = flag_next(r_q.pcs[MMD_WFLAG_BIT], prst_event_in,
               dp_wr && eff_addr[7:0] == MMD_PRST_CS && wdata_in[MMD_WACK_BIT]);
         end
         default: begin
            r_d.st = MMD_ST_LOAD0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         r_q <= '0;
         r_q.st <= MMD_ST_LOAD0;
      end else begin
         r_q <= r_d;
      end
   end

   // Vector lookup; reserved slots and unknown sources give no valid vector
   always_comb begin
      vector_valid_out = 1'b1;
      if (reset_source_in) begin
         vector_addr_out = MMD_VEC_RESET;
      end else begin
         case (irq_source_in)
            4'h0:    vector_addr_out = MMD_VEC_KEYPAD;
            4'h1:    vector_addr_out = MMD_VEC_RTI;
            4'h2:    vector_addr_out = MMD_VEC_LFRX;
            4'h3:    vector_addr_out = MMD_VEC_CONV;
            4'h4:    vector_addr_out = MMD_VEC_RADIO;
            4'h5:    vector_addr_out = MMD_VEC_MEAS;
            4'h6:    vector_addr_out = MMD_VEC_TOVF;
            4'h7:    vector_addr_out = MMD_VEC_CH1;
            4'h8:    vector_addr_out = MMD_VEC_CH0;
            4'h9:    vector_addr_out = MMD_VEC_WAKE;
            4'hA:    vector_addr_out = MMD_VEC_LVOLT;
            4'hB:    vector_addr_out = MMD_VEC_SWI;
            default: begin
               vector_addr_out = MMD_VEC_RESET;
               vector_valid_out = 1'b0;
            end
         endcase
      end
   end

   assign full_addr_out         = (r_q.st == MMD_ST_RUN) ? eff_addr : nvload_addr_out;
   assign sel_param_out         = region == MMD_REG_PARAM;
   assign sel_ram_out           = region == MMD_REG_RAM;
   assign sel_high_out          = region == MMD_REG_HIGH;
   assign sel_flash_out         = region == MMD_REG_FLASH;
   assign sel_firmware_out      = region == MMD_REG_FW;
   assign sel_nvreg_out         = region == MMD_REG_NVREG;
   // Plain writes never reach flash; the erase/program sequencer does that
   assign flash_write_block_out = wr_in && (region == MMD_REG_FLASH || region == MMD_REG_FW ||
                                            region == MMD_REG_NVREG);
   assign fetch_nvload_out      = r_q.st != MMD_ST_RUN;
   assign nvload_addr_out       = (r_q.load_idx == 2'd0) ? MMD_NV_LOAD0 :
                                  (r_q.load_idx == 2'd1) ? MMD_NV_LOAD1 : MMD_NV_LOAD2;
   assign nv_work_out[0]        = r_q.nv0;
   assign nv_work_out[1]        = r_q.nv1;
   assign nv_work_out[2]        = r_q.nv2;
   assign secure_unlock_out     = key_match_in && (r_q.st == MMD_ST_RUN);
   assign rdata_out             = r_q.rdata;
   assign port_a_data_out       = r_q.pa_data[4:0];
   assign port_a_pull_out       = r_q.pa_pull[3:0];
   assign port_a_dir_out        = r_q.pa_dir[3:0];
   assign port_b_data_out       = r_q.pb_data[1:0];
   assign port_b_pull_out       = r_q.pb_pull[1:0];
   assign port_b_dir_out        = r_q.pb_dir[1:0];
   assign keypad_ctrl_out       = r_q.key_sc;
   assign tmr_ctrl_out          = r_q.tmr_sc;
   assign tmr_modulo_out        = r_q.tmr_mod;
   assign tmr_count_clear_out   = r_q.cnt_clr;
   assign tmr_ch0_ctrl_out      = r_q.c0_sc;
   assign tmr_ch0_value_out     = r_q.c0_val;
   assign tmr_ch1_ctrl_out      = r_q.c1_sc;
   assign tmr_ch1_value_out     = r_q.c1_val;
   assign wake_div_out          = r_q.wdiv[5:0];
   assign wake_time_out         = r_q.wcs[5:0];
   assign prst_time_out         = r_q.pcs[5:0];
   assign wake_sel_out          = r_q.wss[7];

endmodule

// >>> mmd_pkg.sv
package mmd_pkg;

   // Memory map regions
   localparam logic [15:0] MMD_DIRECT_LO   = 16'h0000;
   localparam logic [15:0] MMD_DIRECT_HI   = 16'h004F;
   localparam logic [15:0] MMD_PARAM_LO    = 16'h0050;
   localparam logic [15:0] MMD_PARAM_HI    = 16'h008F;
   localparam logic [15:0] MMD_RAM_LO      = 16'h0090;
   localparam logic [15:0] MMD_RAM_HI      = 16'h028F;
   localparam logic [15:0] MMD_HIGH_LO     = 16'h1800;
   localparam logic [15:0] MMD_HIGH_HI     = 16'h182B;
   localparam logic [15:0] MMD_FLASH_LO    = 16'hC000;
   localparam logic [15:0] MMD_USER_TOP    = 16'hDFFF;
   localparam logic [15:0] MMD_FW_LO       = 16'hE000;
   localparam logic [15:0] MMD_JUMP_TABLE  = 16'hE000;
   localparam logic [15:0] MMD_NVREG_LO    = 16'hFFB0;
   localparam logic [15:0] MMD_NVREG_HI    = 16'hFFBF;
   localparam logic [15:0] MMD_NV_KEY_LO   = 16'hFFB0;
   localparam logic [15:0] MMD_NV_KEY_HI   = 16'hFFB7;
   localparam logic [15:0] MMD_NV_LOAD0    = 16'hFFBD;
   localparam logic [15:0] MMD_NV_LOAD1    = 16'hFFBE;
   localparam logic [15:0] MMD_NV_LOAD2    = 16'hFFBF;

   // User vector table
   localparam logic [15:0] MMD_VEC_KEYPAD  = 16'hDFE0;
   localparam logic [15:0] MMD_VEC_RES0    = 16'hDFE2;
   localparam logic [15:0] MMD_VEC_RES1    = 16'hDFE4;
   localparam logic [15:0] MMD_VEC_RTI     = 16'hDFE6;
   localparam logic [15:0] MMD_VEC_LFRX    = 16'hDFE8;
   localparam logic [15:0] MMD_VEC_CONV    = 16'hDFEA;
   localparam logic [15:0] MMD_VEC_RADIO   = 16'hDFEC;
   localparam logic [15:0] MMD_VEC_MEAS    = 16'hDFEE;
   localparam logic [15:0] MMD_VEC_TOVF    = 16'hDFF0;
   localparam logic [15:0] MMD_VEC_CH1     = 16'hDFF2;
   localparam logic [15:0] MMD_VEC_CH0     = 16'hDFF4;
   localparam logic [15:0] MMD_VEC_WAKE    = 16'hDFF6;
   localparam logic [15:0] MMD_VEC_LVOLT   = 16'hDFF8;
   localparam logic [15:0] MMD_VEC_RES2    = 16'hDFFA;
   localparam logic [15:0] MMD_VEC_SWI     = 16'hDFFC;
   localparam logic [15:0] MMD_VEC_RESET   = 16'hDFFE;

   // Direct-page register offsets
   localparam logic [7:0] MMD_PORT_A_DATA     = 8'h00;
   localparam logic [7:0] MMD_PORT_A_PULL     = 8'h01;
   localparam logic [7:0] MMD_PORT_A_DIR      = 8'h03;
   localparam logic [7:0] MMD_PORT_B_DATA     = 8'h04;
   localparam logic [7:0] MMD_PORT_B_PULL     = 8'h05;
   localparam logic [7:0] MMD_PORT_B_DIR      = 8'h07;
   localparam logic [7:0] MMD_KEY_SC          = 8'h0C;
   localparam logic [7:0] MMD_KEY_PE          = 8'h0D;
   localparam logic [7:0] MMD_KEY_ES          = 8'h0E;
   localparam logic [7:0] MMD_TMR_SC          = 8'h10;
   localparam logic [7:0] MMD_TMR_CNTH        = 8'h11;
   localparam logic [7:0] MMD_TMR_CNTL        = 8'h12;
   localparam logic [7:0] MMD_TMR_MODH        = 8'h13;
   localparam logic [7:0] MMD_TMR_MODL        = 8'h14;
   localparam logic [7:0] MMD_TMR_C0SC        = 8'h15;
   localparam logic [7:0] MMD_TMR_C0VH        = 8'h16;
   localparam logic [7:0] MMD_TMR_C0VL        = 8'h17;
   localparam logic [7:0] MMD_TMR_C1SC        = 8'h18;
   localparam logic [7:0] MMD_TMR_C1VH        = 8'h19;
   localparam logic [7:0] MMD_TMR_C1VL        = 8'h1A;
   localparam logic [7:0] MMD_WAKE_DIV        = 8'h1C;
   localparam logic [7:0] MMD_WAKE_CS         = 8'h1D;
   localparam logic [7:0] MMD_PRST_CS         = 8'h1E;
   localparam logic [7:0] MMD_WAKE_SS         = 8'h1F;

   // Implemented-bit masks; bits outside read as zero
   localparam logic [7:0] MMD_MASK_PA_DATA    = 8'h1F;
   localparam logic [7:0] MMD_MASK_NIBBLE     = 8'h0F;
   localparam logic [7:0] MMD_MASK_PAIR       = 8'h03;
   localparam logic [7:0] MMD_MASK_KEY_SC     = 8'h0B;
   localparam logic [7:0] MMD_MASK_CH_SC      = 8'hFC;
   localparam logic [7:0] MMD_MASK_SIX        = 8'h3F;
   localparam logic [7:0] MMD_MASK_WAKE_SS    = 8'hBF;
   localparam logic [7:0] MMD_ZERO8           = 8'h00;

   // Field positions
   localparam int MMD_KEY_FLAG_BIT  = 3;
   localparam int MMD_KEY_ACK_BIT   = 2;
   localparam int MMD_CH_FLAG_BIT   = 7;
   localparam int MMD_TOF_BIT       = 7;
   localparam int MMD_WFLAG_BIT     = 7;
   localparam int MMD_WACK_BIT      = 6;

   typedef enum logic [3:0] {
      MMD_REG_NONE   = 4'h0,
      MMD_REG_DIRECT = 4'h1,
      MMD_REG_PARAM  = 4'h2,
      MMD_REG_RAM    = 4'h3,
      MMD_REG_HIGH   = 4'h4,
      MMD_REG_FLASH  = 4'h5,
      MMD_REG_FW     = 4'h6,
      MMD_REG_NVREG  = 4'h7
   } mmd_region_type;

   typedef enum logic [2:0] {
      MMD_ST_LOAD0 = 3'b001,
      MMD_ST_LOAD1 = 3'b010,
      MMD_ST_RUN   = 3'b100
   } mmd_state_type;

endpackage

// >>> mmd_decode_properties.sv
`timescale 1ns/10ps
module mmd_decode_properties #(parameter int DATA_W = 8) (
   input wire logic              sys_clk_in, rst_n_in, direct_mode_in, rd_in, wr_in, reset_source_in,
   input wire logic              key_match_in, sel_param_out, sel_ram_out, sel_high_out, sel_nvreg_out,
   input wire logic              flash_write_block_out, fetch_nvload_out, vector_valid_out, secure_unlock_out,
   input wire logic [3:0]        irq_source_in,
   input wire logic [15:0]       addr_in, full_addr_out, vector_addr_out,
   input wire logic [DATA_W-1:0] rdata_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic run;
   assign run = !fetch_nvload_out;
   low_byte_a: assert property (run && direct_mode_in |-> full_addr_out == {8'h00, addr_in[7:0]})
      else $error("direct address leaves page zero");
   param_sel_a: assert property (run |-> sel_param_out == (full_addr_out inside {[16'h0050:16'h008F]}))
      else $error("parameter select wrong");
   ram_sel_a: assert property (run |-> sel_ram_out == (full_addr_out inside {[16'h0090:16'h028F]}))
      else $error("ram select wrong");
   high_sel_a: assert property (run |-> sel_high_out == (full_addr_out inside {[16'h1800:16'h182B]}))
      else $error("high page select wrong");
   nvreg_sel_a: assert property (run |-> sel_nvreg_out == (full_addr_out inside {[16'hFFB0:16'hFFBF]}))
      else $error("nonvolatile select wrong");
   reset_vec_a: assert property (reset_source_in |-> vector_valid_out && vector_addr_out == 16'hDFFE)
      else $error("reset vector wrong");
   vec_area_a: assert property (vector_valid_out |-> vector_addr_out inside {[16'hDFE0:16'hDFFE]})
      else $error("vector outside user area");
   vec_range_a: assert property (!reset_source_in && irq_source_in > 4'hB |-> !vector_valid_out)
      else $error("unknown source gave a vector");
   zero_bits_a: assert property (run && rd_in && full_addr_out == 16'h000C |=> rdata_out[7:4] == 4'h0)
      else $error("zero bits of keypad status set");
   key_gate_a: assert property (secure_unlock_out == (key_match_in && run))
      else $error("unlock not tied to key match");
   nv_wr_block_a: assert property (run && wr_in && sel_nvreg_out |-> flash_write_block_out)
      else $error("plain write reached nonvolatile area");
   load_len_a: assert property ($fell(fetch_nvload_out) |-> $past(fetch_nvload_out, 6))
      else $error("nonvolatile load too short");
endmodule
bind mmd_decode mmd_decode_properties #(.DATA_W(DATA_W)) u_props (.*);

// >>> mmd_cpu_model.sv
`timescale 1ns/10ps
module mmd_cpu_model (
   input  wire logic        sys_clk_in,
   input  wire logic [15:0] full_addr_in,
   output logic      [15:0] addr_out,
   output logic             rd_out,
   output logic             wr_out,
   output logic      [7:0]  wdata_out,
   output logic      [7:0]  ext_rdata_out
);
   // Memory bytes follow the address so every read is predictable
   assign ext_rdata_out = full_addr_in[7:0] ^ 8'h3C;
   initial begin
      addr_out = 16'h0000;
      rd_out = 1'b0;
      wr_out = 1'b0;
      wdata_out = 8'h00;
   end
   // One-cycle strobe; address stays put afterwards, released data is inverted
   task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
      @(negedge sys_clk_in);
      addr_out = a;
      wdata_out = d;
      rd_out = !wr;
      wr_out = wr;
      @(negedge sys_clk_in);
      rd_out = 1'b0;
      wr_out = 1'b0;
      wdata_out = ~d;
   endtask
endmodule

// >>> testbench.sv
`timescale 1ns/10ps
module testbench;
   import mmd_pkg::*;
   logic        sys_clk_in = 1'b0, rst_n_in = 1'b0, direct_mode_in = 1'b0, rd_in, wr_in, reset_source_in = 1'b0;
   logic        event_pulse = 1'b0, key_match_in = 1'b0, sel_param_out, sel_ram_out, sel_high_out;
   logic        sel_firmware_out, sel_nvreg_out, fetch_nvload_out, vector_valid_out, secure_unlock_out, sel_flash_out;
   logic [3:0]  irq_source_in = 4'h0;
   logic [4:0]  port_a_data_out;
   logic [5:0]  regions;
   logic [7:0]  wdata_in, ext_rdata_in, rdata_out, nv_work_out [3];
   logic [15:0] addr_in, full_addr_out, vector_addr_out, tmr_modulo_out;
   int          n_errors = 0, compares = 0;
   assign regions = {sel_param_out, sel_ram_out, sel_high_out, sel_firmware_out, sel_nvreg_out, sel_flash_out};
   always #20 sys_clk_in = ~sys_clk_in;
   mmd_cpu_model cpu (.sys_clk_in, .full_addr_in(full_addr_out), .addr_out(addr_in), .rd_out(rd_in),
      .wr_out(wr_in), .wdata_out(wdata_in), .ext_rdata_out(ext_rdata_in));
   mmd_decode dut (.sys_clk_in, .rst_n_in, .addr_in, .direct_mode_in, .rd_in, .wr_in, .wdata_in, .ext_rdata_in,
      .keypad_event_in(event_pulse), .tmr_ovf_in(event_pulse), .tmr_ch0_in(event_pulse), .tmr_ch1_in(event_pulse),
      .wake_event_in(event_pulse), .prst_event_in(event_pulse), .tmr_count_in(16'h1234), .wake_count_in(6'h15),
      .reset_source_in, .irq_source_in, .key_match_in, .rdata_out, .full_addr_out, .sel_param_out, .sel_ram_out,
      .sel_high_out, .sel_flash_out, .sel_firmware_out, .sel_nvreg_out, .flash_write_block_out(),
      .fetch_nvload_out, .nvload_addr_out(), .vector_addr_out, .vector_valid_out, .nv_work_out, .secure_unlock_out,
      .port_a_data_out, .port_a_pull_out(), .port_a_dir_out(), .port_b_data_out(), .port_b_pull_out(),
      .port_b_dir_out(), .keypad_ctrl_out(), .tmr_ctrl_out(), .tmr_modulo_out, .tmr_count_clear_out(),
      .tmr_ch0_ctrl_out(), .tmr_ch0_value_out(), .tmr_ch1_ctrl_out(), .tmr_ch1_value_out(), .wake_div_out(),
      .wake_time_out(), .prst_time_out(), .wake_sel_out());
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic t_load();
      repeat (2) @(negedge sys_clk_in);
      for (int i = 0; i < 20 && fetch_nvload_out !== 1'b0; i++) @(negedge sys_clk_in);
      chk("load_done", 16'(fetch_nvload_out), 16'h0000);
      for (int i = 0; i < 3; i++) chk("nv_work", 16'(nv_work_out[i]), 16'h0081 + 16'(i));
   endtask
   task automatic t_map();
      logic [15:0] a [12] = '{16'h004F, 16'h0050, 16'h008F, 16'h0090, 16'h028F, 16'h0290, 16'h1800, 16'h182B,
                              16'h182C, 16'hC000, 16'hE000, 16'hFFBF};
      logic [5:0]  e [12] = '{6'h00, 6'h20, 6'h20, 6'h10, 6'h10, 6'h00, 6'h08, 6'h08, 6'h00, 6'h01, 6'h04, 6'h02};
      for (int i = 0; i < 12; i++) begin
         cpu.access(1'b0, a[i], 8'h00);
         chk("region", 16'(regions), 16'(e[i]));
         if (e[i][5:4] != 2'h0) chk("mem_data", 16'(rdata_out), 16'(a[i][7:0] ^ 8'h3C));
      end
      cpu.access(1'b1, 16'hFFB0, 8'h55);
   endtask
   task automatic t_vec();
      logic [7:0] lo [12] = '{8'hE0, 8'hE6, 8'hE8, 8'hEA, 8'hEC, 8'hEE, 8'hF0, 8'hF2, 8'hF4, 8'hF6, 8'hF8, 8'hFC};
      for (int i = 0; i < 13; i++) begin
         @(negedge sys_clk_in);
         irq_source_in = 4'(i);
         #1;
         if (i < 12) chk("vector", vector_addr_out, {8'hDF, lo[i]});
         chk("vector_valid", 16'(vector_valid_out), 16'(i < 12));
      end
      @(negedge sys_clk_in);
      reset_source_in = 1'b1;
      #1;
      chk("reset_vector", vector_addr_out, 16'hDFFE);
   endtask
   task automatic t_regs();
      cpu.access(1'b1, 16'h0013, 8'hAB);
      chk("modulo_high", 16'(tmr_modulo_out[15:8]), 16'h00AB);
      cpu.access(1'b1, 16'h0000, 8'hFF);
      cpu.access(1'b1, 16'h0002, 8'h00);
      chk("port_a", 16'(port_a_data_out), 16'h001F);
      cpu.access(1'b1, 16'h0015, 8'h7F);
      cpu.access(1'b0, 16'h0015, 8'h00);
      chk("chan0_ctrl", 16'(rdata_out), 16'h007C);
      direct_mode_in = 1'b1;
      cpu.access(1'b0, 16'h1800, 8'h00);
      chk("direct_addr", full_addr_out, 16'h0000);
      chk("direct_read", 16'(rdata_out), 16'h001F);
      direct_mode_in = 1'b0;
      event_pulse = 1'b1;
      cpu.access(1'b1, 16'h000C, 8'h04);
      event_pulse = 1'b0;
      cpu.access(1'b0, 16'h000C, 8'h00);
      chk("keypad_status", 16'(rdata_out), 16'h0008);
      key_match_in = 1'b1;
      #1;
      chk("unlock", 16'(secure_unlock_out), 16'h0001);
   endtask
   initial begin
      repeat (3) @(negedge sys_clk_in);
      rst_n_in = 1'b1;
      t_load();
      t_map();
      t_vec();
      t_regs();
      report_and_stop();
   end
   initial begin
      repeat (2000) @(posedge sys_clk_in);
      n_errors++;
      report_and_stop();
   end
endmodule
